// [src/tpf_pkg.sv]
// Constants shared by the telemetry PCM formatter.
package tpf_pkg;
   localparam int unsigned CLK_HZ    = 20_000_000;
   localparam int unsigned CHIPS_BIT = 9;
   // Bit rates in tenths of a bit per second.
   localparam int unsigned RATE1_X10 = 150000;
   localparam int unsigned RATE2_X10 = 75000;
   localparam int unsigned RATE3_X10 = 37500;
   localparam int unsigned RATE4_X10 = 18750;
   localparam int unsigned RATE5_X10 = 2344;
   localparam int unsigned RATE6_X10 = 73;
   localparam int unsigned CHIP_R1 = CLK_HZ * 10 / (RATE1_X10 * CHIPS_BIT);
   localparam int unsigned CHIP_R2 = CLK_HZ * 10 / (RATE2_X10 * CHIPS_BIT);
   localparam int unsigned CHIP_R3 = CLK_HZ * 10 / (RATE3_X10 * CHIPS_BIT);
   localparam int unsigned CHIP_R4 = CLK_HZ * 10 / (RATE4_X10 * CHIPS_BIT);
   localparam int unsigned CHIP_R5 = CLK_HZ * 10 / (RATE5_X10 * CHIPS_BIT);
   localparam int unsigned CHIP_R6 = CLK_HZ * 10 / (RATE6_X10 * CHIPS_BIT);
   localparam logic [3:0]  CHIP_LAST = 4'h8;
   localparam logic [2:0]  BIT_LAST  = 3'h6;
   localparam logic [4:0]  SLOT_LAST = 5'h1F;
   localparam logic [4:0]  SLOT_FCNT = 5'h03;
   localparam logic [4:0]  SLOT_MODW = 5'h04;
   localparam logic [4:0]  SLOT_EVT  = 5'h05;
   localparam logic [4:0]  SLOT_ELP  = 5'h08;
   localparam logic [4:0]  SLOT_STAT = 5'h0A;
   localparam logic [4:0]  SLOT_CAP  = 5'h0C;
   localparam logic [4:0]  SLOT_PLAY = 5'h10;
   localparam logic [4:0]  SLOT_MID  = 5'h15;
   localparam logic [20:0] SYNC_CODE = 21'h1F35A2;
   localparam logic [5:0]  PN_SEED   = 6'h3F;
   localparam logic [8:0]  FRM_LAST  = 9'h18F;
   localparam logic [1:0]  MODE_ENG  = 2'h0;
   localparam logic [1:0]  MODE_SCI  = 2'h1;
   localparam logic [1:0]  MODE_PLAY = 2'h2;
   localparam logic [1:0]  MODE_SEQ  = 2'h3;
   localparam logic [1:0]  SRC_WORD  = 2'h0;
   localparam logic [1:0]  SRC_SCI   = 2'h1;
   localparam logic [1:0]  SRC_REC   = 2'h2;
   localparam logic [1:0]  SRC_SEQ   = 2'h3;
   localparam logic [7:0]  OFS_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_STAT  = 8'h04;
   localparam logic [7:0]  OFS_EVT   = 8'h08;
   localparam logic [7:0]  OFS_ELP   = 8'h0C;
   localparam int          F_RATE    = 2;
   localparam int          F_TRSEL   = 5;
   localparam int          F_RUN     = 8;
   localparam int          F_MANV    = 9;
   localparam int          F_OVR     = 7;
endpackage : tpf_pkg

// [src/tpf_formatter.sv]
// Telemetry PCM frame formatter with APB control registers.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Converted analog samples sent as seven-bit words.
// (R2) Wide digital values split over consecutive words.
// (R3) Six selectable bit rates, slowest for emergency.
// (R4) Mode one carries engineering and capsule words.
// (R5) Mode two adds real-time science data.
// (R6) Mode three plays back recorder data.
// (R7) Mode four adds sequencer memory readout.
// (R8) Sync, frame-count and mode words generated here.
// (R9) Slot layout follows the active data mode.
// (R10) Data bit combined with pseudonoise chip.
// (R11) Async capsule data buffered, re-timed, inserted.
// (R12) Stored capsule data played back on bit clock.
// (R13) Event pulses counted and telemetered.
// (R14) Interval between event pulses measured.
// (R15) On-off status inputs sent as words.
// (R16) Engineering channels in four sampling groups.
// (R17) Sequencer separation moves capsule input to radio.
// (R18) Bit clock supplied to the tape recorders.
// (R19) Capsule receiver gives data with bit sync.
// (R20) Recorder plays back at telemetry rate.
// (R21) Sequencer supplies data mode selections.
// (R22) 63-chip pseudonoise code repeats every word.
// (R23) Each frame opens with 21-bit sync code.
// (R24) Recorder data gap reverts to real-time data.
// (R25) Mode and rate change only at frame boundary.
// (R26) Words shifted out serially, MSB first.
module tpf_formatter
   import tpf_pkg::*;
#(
   parameter int unsigned CHIP_R1_P = CHIP_R1,
   parameter int unsigned CHIP_R2_P = CHIP_R2,
   parameter int unsigned CHIP_R3_P = CHIP_R3,
   parameter int unsigned CHIP_R4_P = CHIP_R4,
   parameter int unsigned CHIP_R5_P = CHIP_R5,
   parameter int unsigned CHIP_R6_P = CHIP_R6
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  eng_sample,
   output logic      [10:0] eng_chan,
   input  wire logic [13:0] status_in,
   input  wire logic        event_pulse,
   input  wire logic        sci_data,
   output logic             sci_gate,
   input  wire logic        seq_data,
   output logic             seq_gate,
   output logic             seq_word_end,
   input  wire logic [6:0]  rec_data,
   input  wire logic [6:0]  rec_gap,
   input  wire logic [6:0]  rec_eot,
   output logic             rec_gate,
   output logic      [2:0]  tape_recorder_select,
   output logic             maneuver_store,
   input  wire logic        separation,
   input  wire logic        cap_hw_data,
   input  wire logic        cap_hw_sync,
   input  wire logic        cap_rf_data,
   input  wire logic        cap_rf_sync,
   output logic             bit_clk,
   output logic             word_tick,
   output logic             frame_tick,
   output logic      [1:0]  mode_out,
   output logic             pn_chip,
   output logic             tlm_out
);
   logic [1:0]  mode_sel, act_mode, eff_mode, src, next_src;
   logic [2:0]  rate_sel, act_rate, bit_idx, cap_n;
   logic        run, gap, cap_full, cap_ovr, data_bit, evt_d;
   logic [18:0] chip_cnt, chip_per;
   logic [3:0]  chip_idx, eng_idx;
   logic [4:0]  slot, ns;
   logic [8:0]  frame_cnt;
   logic [6:0]  word_reg, next_word, cap_sh, cap_word;
   logic [5:0]  pn;
   logic [15:0] evt_cnt, evt_snap;
   logic [13:0] elp_run, elp_last;
   logic        cap_dm, cap_ds, cap_cm, cap_cs, cap_cd;
   logic        chip_tick, bit_end, word_end, frame_end, evt_rise;
   logic        cap_rise, cap_done, cap_take, next_ser, ser_in, wr;
   logic [20:0] evt_w;
   logic [31:0] rd_val;
   logic        addr_ok;

   // Chip timebase: nine chips per bit, seven bits per word. See (R3) (R22)
   always_comb begin
      case (act_rate)
         3'h0: chip_per = 19'(CHIP_R1_P - 1);
         3'h1: chip_per = 19'(CHIP_R2_P - 1);
         3'h2: chip_per = 19'(CHIP_R3_P - 1);
         3'h3: chip_per = 19'(CHIP_R4_P - 1);
         3'h4: chip_per = 19'(CHIP_R5_P - 1);
         default: chip_per = 19'(CHIP_R6_P - 1);
      endcase
   end

   assign chip_tick = run && (chip_cnt == 19'h00000);
   assign bit_end   = chip_tick && (chip_idx == CHIP_LAST);
   assign word_end  = bit_end && (bit_idx == BIT_LAST);
   assign frame_end = word_end && (slot == SLOT_LAST);
   assign ns        = slot + 5'h01;

   // A stopped formatter parks at the last chip so the first run cycle opens a frame.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_cnt <= 19'h00000;
         chip_idx <= CHIP_LAST;
         bit_idx  <= BIT_LAST;
         slot     <= SLOT_LAST;
      end else if (!run) begin
         chip_cnt <= 19'h00000;
         chip_idx <= CHIP_LAST;
         bit_idx  <= BIT_LAST;
         slot     <= SLOT_LAST;
      end else if (chip_tick) begin
         chip_cnt <= chip_per;
         chip_idx <= bit_end ? 4'h0 : chip_idx + 4'h1;
         if (bit_end) begin
            bit_idx <= word_end ? 3'h0 : bit_idx + 3'h1;
         end
         if (word_end) begin
            slot <= ns;
         end
      end else begin
         chip_cnt <= chip_cnt - 19'h00001;
      end
   end

   // Selections wait for the frame boundary so no frame mixes layouts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_mode  <= MODE_ENG;
         act_rate  <= 3'h0;
         frame_cnt <= 9'h000;
         evt_snap  <= 16'h0000;
      end else if (!run || frame_end) begin
         act_mode <= mode_sel; // see (R25) (R21)
         act_rate <= (rate_sel > 3'h5) ? 3'h5 : rate_sel; // see (R25) (R3)
         if (frame_end) begin
            frame_cnt <= (frame_cnt == FRM_LAST) ? 9'h000 : frame_cnt + 9'h001;
            evt_snap  <= evt_cnt;
         end
      end
   end

   assign gap = (tape_recorder_select < 3'h7) &&
                (rec_gap[tape_recorder_select] || rec_eot[tape_recorder_select]);
   assign eff_mode = (act_mode == MODE_PLAY && gap) ? MODE_SCI : act_mode; // see (R24)
   assign evt_w = {5'h00, evt_snap};

   // Slot contents for the word about to start.
   always_comb begin
      next_word = 7'h00;
      next_src  = SRC_WORD;
      if (ns < SLOT_FCNT) begin
         next_word = SYNC_CODE[20 - 7 * ns[1:0] -: 7]; // see (R23) (R8)
      end else if (ns == SLOT_FCNT) begin
         next_word = frame_cnt[6:0]; // see (R8)
      end else if (ns == SLOT_MODW) begin
         next_word = {act_mode, act_rate, gap, frame_cnt[7]}; // see (R8)
      end else if (ns < SLOT_ELP) begin
         next_word = evt_w[20 - 7 * (ns - SLOT_EVT) -: 7]; // see (R2) (R13)
      end else if (ns < SLOT_STAT) begin
         next_word = (ns == SLOT_ELP) ? elp_last[13:7] : elp_last[6:0]; // see (R2) (R14)
      end else if (ns < SLOT_CAP) begin
         next_word = (ns == SLOT_STAT) ? status_in[13:7] : status_in[6:0]; // see (R15)
      end else if (ns == SLOT_CAP) begin
         next_word = (eff_mode == MODE_PLAY) ? 7'h00 : cap_word; // see (R11) (R4)
      end else begin
         next_word = eng_sample; // see (R1) (R4) (R9)
         case (eff_mode)
            MODE_SCI: if (ns >= SLOT_MID) next_src = SRC_SCI; // see (R5)
            MODE_PLAY: if (ns >= SLOT_PLAY) next_src = SRC_REC; // see (R6)
            MODE_SEQ: if (ns >= SLOT_MID) next_src = SRC_SEQ; // see (R7)
            default: next_src = SRC_WORD;
         endcase
      end
   end

   function automatic logic pick(input logic [1:0] s, input logic [2:0] sel,
                                 input logic sci, input logic seq, input logic [6:0] rec);
      case (s)
         SRC_SCI: pick = sci;
         SRC_REC: pick = (sel < 3'h7) ? rec[sel] : 1'b0;
         SRC_SEQ: pick = seq;
         default: pick = 1'b0;
      endcase
   endfunction : pick

   assign next_ser = pick(next_src, tape_recorder_select, sci_data, seq_data, rec_data);
   assign ser_in   = pick(src, tape_recorder_select, sci_data, seq_data, rec_data);

   // Serial sources bypass the word register, one bit per bit period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_reg <= 7'h00;
         src      <= SRC_WORD;
         data_bit <= 1'b0;
      end else if (word_end) begin
         word_reg <= next_word;
         src      <= next_src;
         data_bit <= (next_src == SRC_WORD) ? next_word[6] : next_ser; // see (R26) (R12)
      end else if (bit_end) begin
         word_reg <= {word_reg[5:0], 1'b0};
         data_bit <= (src == SRC_WORD) ? word_reg[5] : ser_in; // see (R26)
      end
   end

   // Engineering commutator points one word ahead so the converter can settle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_idx  <= 4'h0;
         eng_chan <= 11'h000;
      end else begin
         if (frame_end) begin
            eng_idx <= 4'h0;
         end else if (word_end && ns > SLOT_CAP && next_src == SRC_WORD) begin
            eng_idx <= (eng_idx == 4'hF) ? eng_idx : eng_idx + 4'h1;
         end
         case (eng_idx)
            4'h4: eng_chan <= {2'h1, frame_cnt % 9'h014}; // see (R16)
            4'h5: eng_chan <= {2'h2, frame_cnt % 9'h0C8}; // see (R16)
            4'h6: eng_chan <= {2'h3, frame_cnt}; // see (R16)
            default: eng_chan <= {7'h00, eng_idx}; // see (R16)
         endcase
      end
   end

   // PN code restarts each word: 63 chips per seven-bit word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pn      <= PN_SEED;
         pn_chip <= 1'b0;
         tlm_out <= 1'b0;
      end else begin
         if (!run || word_end) begin
            pn <= PN_SEED; // see (R22)
         end else if (chip_tick) begin
            pn <= {pn[4:0], pn[5] ^ pn[4]}; // see (R22)
         end
         pn_chip <= pn[5];
         tlm_out <= data_bit ^ pn[5]; // see (R10)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_clk      <= 1'b0;
         word_tick    <= 1'b0;
         frame_tick   <= 1'b0;
         seq_word_end <= 1'b0;
      end else begin
         bit_clk      <= run && (chip_idx < 4'h4 || bit_end); // see (R18) (R20)
         word_tick    <= word_end;
         frame_tick   <= frame_end;
         seq_word_end <= word_end && (src == SRC_SEQ);
      end
   end

   // Gates open in the word-end cycle, because the first serial bit is taken there.
   assign sci_gate = run && (word_end ? next_src == SRC_SCI : src == SRC_SCI); // see (R5)
   assign rec_gate = run && (word_end ? next_src == SRC_REC : src == SRC_REC); // see (R6)
   assign seq_gate = run && (word_end ? next_src == SRC_SEQ : src == SRC_SEQ); // see (R7)
   assign mode_out = eff_mode;

   // Capsule line is asynchronous, so both wires pass two flip-flops first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_dm <= 1'b0;
         cap_ds <= 1'b0;
         cap_cm <= 1'b0;
         cap_cs <= 1'b0;
         cap_cd <= 1'b0;
      end else begin
         cap_dm <= separation ? cap_rf_data : cap_hw_data; // see (R17) (R19)
         cap_ds <= cap_dm;
         cap_cm <= separation ? cap_rf_sync : cap_hw_sync; // see (R17) (R19)
         cap_cs <= cap_cm;
         cap_cd <= cap_cs;
      end
   end

   assign cap_rise = cap_cs && !cap_cd;
   assign cap_done = cap_rise && (cap_n == BIT_LAST);
   assign cap_take = word_end && (ns == SLOT_CAP) && (eff_mode != MODE_PLAY);
   assign wr       = psel && penable && pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_sh   <= 7'h00;
         cap_n    <= 3'h0;
         cap_word <= 7'h00;
         cap_full <= 1'b0;
         cap_ovr  <= 1'b0;
      end else begin
         if (cap_rise) begin
            cap_sh <= {cap_sh[5:0], cap_ds};
            cap_n  <= cap_done ? 3'h0 : cap_n + 3'h1;
         end
         if (cap_done) begin
            cap_word <= {cap_sh[5:0], cap_ds}; // see (R11)
         end
         if (cap_done) begin
            cap_full <= 1'b1; // see (R11)
         end else if (cap_take) begin
            cap_full <= 1'b0;
         end
         if (cap_done && cap_full && !cap_take) begin
            cap_ovr <= 1'b1;
         end else if (wr && paddr == OFS_STAT && pwdata[F_OVR]) begin
            cap_ovr <= 1'b0;
         end
      end
   end

   assign evt_rise = event_pulse && !evt_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_d    <= 1'b0;
         evt_cnt  <= 16'h0000;
         elp_run  <= 14'h0000;
         elp_last <= 14'h0000;
      end else begin
         evt_d <= event_pulse;
         if (evt_rise) begin
            evt_cnt  <= evt_cnt + 16'h0001; // see (R13)
            elp_last <= elp_run; // see (R14)
            elp_run  <= 14'h0000;
         end else if (bit_end && elp_run != 14'h3FFF) begin
            elp_run <= elp_run + 14'h0001; // see (R14)
         end
      end
   end

   // APB slave: no wait states, data prepared in the setup cycle.
   assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                    (paddr == OFS_EVT) || (paddr == OFS_ELP);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_comb begin
      case (paddr)
         OFS_CTRL: rd_val = {22'h000000, maneuver_store, run, tape_recorder_select,
                             rate_sel, mode_sel};
         OFS_STAT: rd_val = {15'h0000, frame_cnt, cap_ovr, cap_full, gap,
                             act_rate, act_mode};
         OFS_EVT:  rd_val = {16'h0000, evt_cnt};
         OFS_ELP:  rd_val = {18'h00000, elp_last};
         default:  rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata               <= 32'h00000000;
         mode_sel             <= MODE_ENG;
         rate_sel             <= 3'h0;
         tape_recorder_select <= 3'h0;
         run                  <= 1'b0;
         maneuver_store       <= 1'b0;
      end else begin
         if (psel && !penable) begin
            prdata <= rd_val;
         end
         if (wr && paddr == OFS_CTRL) begin
            mode_sel             <= pwdata[1:0];
            rate_sel             <= pwdata[F_RATE +: 3];
            tape_recorder_select <= pwdata[F_TRSEL +: 3];
            run                  <= pwdata[F_RUN];
            maneuver_store       <= pwdata[F_MANV];
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sync_first;
      frame_end |=> word_reg == SYNC_CODE[20:14];
   endproperty
   a_sync_first: assert property (p_sync_first) else $error("Sync word missing."); // see (R23)
   property p_pn_seed;
      word_end |=> pn == PN_SEED;
   endproperty
   a_pn_seed: assert property (p_pn_seed) else $error("PN not restarted."); // see (R22)
   property p_mode_hold;
      !$stable(act_mode) |-> $past(frame_end) || $past(!run);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("Mode changed mid frame."); // see (R25)
   property p_msb_order;
      bit_end && !word_end && src == SRC_WORD |=> data_bit == $past(word_reg[5]);
   endproperty
   a_msb_order: assert property (p_msb_order) else $error("Bit order wrong."); // see (R26)
   property p_cap_fill;
      cap_done |=> cap_full ##0 cap_word == $past({cap_sh[5:0], cap_ds});
   endproperty
   a_cap_fill: assert property (p_cap_fill) else $error("Capsule word lost."); // see (R11)
   property p_evt_count;
      evt_rise |=> evt_cnt == $past(evt_cnt) + 16'h0001;
   endproperty
   a_evt_count: assert property (p_evt_count) else $error("Event not counted."); // see (R13)
   property p_gap_revert;
      act_mode == MODE_PLAY && gap |-> mode_out == MODE_SCI;
   endproperty
   a_gap_revert: assert property (p_gap_revert) else $error("Gap not handled."); // see (R24)
   property p_rate_period;
      chip_tick |=> chip_cnt == $past(chip_per);
   endproperty
   a_rate_period: assert property (p_rate_period) else $error("Chip period wrong."); // see (R3)
   property p_mode_word;
      word_end && ns == SLOT_MODW |=> word_reg[6:2] == {act_mode, act_rate};
   endproperty
   a_mode_word: assert property (p_mode_word) else $error("Mode word wrong."); // see (R8)
   c_frame: cover property (frame_end);
   c_cap_take: cover property (cap_take && cap_full);
   c_gap: cover property (act_mode == MODE_PLAY && gap && word_end);
endmodule : tpf_formatter
`default_nettype wire

// [verif/tpf_partner.sv]
// Far-side model: science, sequencer, recorders and capsule receiver.
`timescale 1ns/1ps
`default_nettype none
module tpf_partner (
   input  wire logic       bit_clk,
   input  wire logic       sci_gate,
   input  wire logic       seq_gate,
   input  wire logic       rec_gate,
   input  wire logic [2:0] tape_recorder_select,
   output logic            sci_data,
   output logic            seq_data,
   output logic      [6:0] rec_data,
   output logic      [6:0] rec_gap,
   output logic      [6:0] rec_eot,
   output logic            cap_hw_data,
   output logic            cap_hw_sync,
   output logic            cap_rf_data,
   output logic            cap_rf_sync
);
   logic gap_on = 1'b0;
   logic cd     = 1'b0;
   logic cs     = 1'b0;
   logic rf     = 1'b0;
   // Released lines toggle, so a stale level can never pass for data.
   assign sci_data    = sci_gate ? 1'b1 : bit_clk;
   assign seq_data    = seq_gate ? 1'b0 : ~bit_clk;
   assign rec_data    = rec_gate ? (7'h01 << tape_recorder_select) : {7{bit_clk}};
   assign rec_gap     = gap_on ? (7'h01 << tape_recorder_select) : 7'h00;
   assign rec_eot     = 7'h00;
   assign cap_hw_data = ~rf & cd;
   assign cap_hw_sync = ~rf & cs;
   assign cap_rf_data = rf & cd;
   assign cap_rf_sync = rf & cs;
   // The sync line stands still between words.
   task automatic send_capsule(input logic [6:0] v, input logic on_rf);
      rf = on_rf;
      for (int i = 6; i >= 0; i--) begin
         cd = v[i];
         #2000 cs = 1'b1;
         #2000 cs = 1'b0;
      end
      cd = ~cd;
   endtask : send_capsule
endmodule : tpf_partner
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the telemetry PCM formatter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tpf_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [6:0]  eng_sample = 7'h33;
   logic [13:0] status_in = 14'h2A5C;
   logic        event_pulse = 1'b0;
   logic        separation = 1'b0;
   logic [31:0] prdata, rd, m_sci, m_seq, m_rec;
   logic [6:0]  rec_data, rec_gap, rec_eot, w[32], fc1;
   logic [2:0]  tape_recorder_select;
   logic [1:0]  mode_out;
   logic [20:0] p;
   logic        pready, pslverr, er, sci_data, sci_gate, seq_data, seq_gate, rec_gate;
   logic        cap_hw_data, cap_hw_sync, cap_rf_data, cap_rf_sync, maneuver_store;
   logic        bit_clk, frame_tick, pn_chip, tlm_out, bc_d, word_tick, seq_word_end;
   int          n_fail = 0, cmp_count = 0, rises = 0, rises_last = 0, wt = 0, swe = 0;

   // Small chip periods keep a frame near eight thousand cycles; no scenario runs rate five.
   tpf_formatter #(.CHIP_R1_P(4), .CHIP_R2_P(4), .CHIP_R3_P(4), .CHIP_R4_P(4),
      .CHIP_R6_P(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .eng_sample, .eng_chan(), .status_in,
      .event_pulse, .sci_data, .sci_gate, .seq_data, .seq_gate, .seq_word_end, .rec_data,
      .rec_gap, .rec_eot, .rec_gate, .tape_recorder_select, .maneuver_store, .separation,
      .cap_hw_data, .cap_hw_sync, .cap_rf_data, .cap_rf_sync, .bit_clk, .word_tick,
      .frame_tick, .mode_out, .pn_chip, .tlm_out);
   tpf_partner far (.bit_clk, .sci_gate, .seq_gate, .rec_gate, .tape_recorder_select,
      .sci_data, .seq_data, .rec_data, .rec_gap, .rec_eot, .cap_hw_data, .cap_hw_sync,
      .cap_rf_data, .cap_rf_sync);

   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      bc_d <= bit_clk;
      if (frame_tick === 1'b1) begin
         rises_last <= rises;
         rises <= int'(bit_clk & ~bc_d);
         wt <= int'(word_tick);
         swe <= int'(seq_word_end);
      end else begin
         rises <= rises + int'(bit_clk & ~bc_d);
         wt <= wt + int'(word_tick);
         swe <= swe + int'(seq_word_end);
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] ctrl(logic [1:0] m, logic [2:0] r, logic run);
      return 32'(m) | (32'(r) << F_RATE) | (32'h2 << F_TRSEL) | (32'(run) << F_RUN);
   endfunction : ctrl

   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (frame_tick !== 1'b1 && n < 20000);
      chk("frame_tick", frame_tick, 1'b1);
   endtask : wait_tick

   // Samples each bit at its middle and strips the chip to recover data.
   task automatic get_frame();
      wait_tick();
      for (int b = 0; b < 224; b++) begin
         repeat (b == 0 ? 18 : 36) @(negedge pclk);
         w[b/7] = {w[b/7][5:0], tlm_out ^ pn_chip};
         if (b < 21) p[b] = pn_chip;
         if (b % 7 == 3) begin
            m_sci[b/7] = sci_gate;
            m_seq[b/7] = seq_gate;
            m_rec[b/7] = rec_gate;
         end
      end
   endtask : get_frame

   task automatic check_mode(input logic [1:0] m, input logic [2:0] r, input logic gap,
      input logic [31:0] es, eq, erc, input int slot, input logic [6:0] v);
      chk("mode_out", mode_out, gap ? MODE_SCI : m);
      chk("mode word", w[4][6:1], {m, r, gap});
      chk("sci gate", m_sci, es);
      chk("seq gate", m_seq, eq);
      chk("rec gate", m_rec, erc);
      chk("payload", w[slot], v);
      chk("sync", {w[0], w[1], w[2]}, SYNC_CODE);
   endtask : check_mode

   task automatic test_regs();
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h000002FF);
      apb(1'b1, OFS_EVT, 32'h0000FFFF);
      apb(1'b1, 8'h40, 32'h0);
      chk("unmapped err", er, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl rw", rd, 32'h000002FF);
      chk("recorder select", tape_recorder_select, 3'h7);
      chk("maneuver", maneuver_store, 1'b1);
      apb(1'b1, OFS_CTRL, ctrl(MODE_ENG, 3'h0, 1'b0));
      repeat (5) begin
         @(posedge pclk) event_pulse <= 1'b1;
         @(posedge pclk) event_pulse <= 1'b0;
      end
      apb(1'b0, OFS_EVT, 32'h0);
      chk("event count", rd, 32'h5);
      far.send_capsule(7'h4B, 1'b0);
   endtask : test_regs

   task automatic test_first_frame();
      apb(1'b1, OFS_CTRL, ctrl(MODE_ENG, 3'h0, 1'b1));
      get_frame();
      check_mode(MODE_ENG, 3'h0, 1'b0, 0, 0, 0, 13, 7'h33);
      chk("events", {w[5], w[6], w[7]}, 21'h000005);
      chk("status", {w[10], w[11]}, 14'h2A5C);
      chk("capsule", w[12], 7'h4B);
      chk("word ticks", wt, 32);
      chk("pn", p[6:0], p[13:7]);
      chk("pn", p[13:7], p[20:14]);
      fc1 = w[3];
   endtask : test_first_frame

   task automatic test_mode_switch();
      wait_tick();
      apb(1'b1, OFS_CTRL, ctrl(MODE_SCI, 3'h1, 1'b1));
      apb(1'b0, OFS_STAT, 32'h0);
      chk("held mode", rd[4:0], {3'h0, MODE_ENG});
      repeat (3400) @(posedge pclk);
      separation <= 1'b1;
      far.send_capsule(7'h2D, 1'b1);
      get_frame();
      check_mode(MODE_SCI, 3'h1, 1'b0, 32'hFFE00000, 0, 0, 21, 7'h7F);
      chk("frame count", w[3], fc1 + 7'h02);
      chk("radio capsule", w[12], 7'h2D);
      chk("bit clocks", rises_last, 224);
   endtask : test_mode_switch

   task automatic test_playback();
      apb(1'b1, OFS_CTRL, ctrl(MODE_PLAY, 3'h2, 1'b1));
      get_frame();
      check_mode(MODE_PLAY, 3'h2, 1'b0, 0, 0, 32'hFFFF0000, 16, 7'h7F);
      far.gap_on = 1'b1;
      apb(1'b1, OFS_CTRL, ctrl(MODE_PLAY, 3'h5, 1'b1));
      get_frame();
      check_mode(MODE_PLAY, 3'h5, 1'b1, 32'hFFE00000, 0, 0, 21, 7'h7F);
      far.gap_on = 1'b0;
   endtask : test_playback

   task automatic test_sequencer();
      apb(1'b1, OFS_CTRL, ctrl(MODE_SEQ, 3'h3, 1'b1));
      get_frame();
      check_mode(MODE_SEQ, 3'h3, 1'b0, 0, 32'hFFE00000, 0, 21, 7'h00);
      chk("sequencer word ends", swe, 10);
   endtask : test_sequencer

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_first_frame();
      test_mode_switch();
      test_playback();
      test_sequencer();
      report_and_stop();
   end

   initial begin
      repeat (100000) @(posedge pclk);
      n_fail++;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
